/* fpl_top.sv */
// Overview of operation
// [R1] Current limit runs fault timer, expiry latches off
// [R2] Leaving current limit early clears fault timer
// [R3] Max on-time termination also runs fault timer
// [R4] Autorecovery builds restart after autorecovery delay
// [R5] Brown-out or supply reset releases latch
// [R6] Four consecutive short-sense pulses latch off
// [R7] Low supply for 10 us latches off
// [R8] Fault pin outside window latches off
// [R9] Fault-pin autorecovery is a build option
// [R10] Blank fault-pin spikes: 50 us high, 350 us low
// [R11] Brown-out or supply reset clears fault-pin latch
// [R12] High fault threshold checked from supply turn-on
// [R13] Low fault threshold checked after soft-start
// [R14] Doubled bias current during soft-start
// [R15] Thermal shutdown stops gate, supply kept alive
// [R16] Thermal clear restarts with soft-start
// [R17] Max on, duty, pin, overvoltage: no autorecovery
// [R18] Brown-out stops; restart needs line and supply
// [R19] Off mode on low feedback, resume on valid
`timescale 1ns/1ps
module fpl_top
   import fpl_pkg::*;
#(
   parameter int unsigned FAULT_TIMER_LEN = FAULT_TIMER_CYC,
   parameter int unsigned AUTOREC_LEN     = AUTOREC_CYC,
   parameter int unsigned SOFTSTART_LEN   = SOFTSTART_CYC,
   parameter int unsigned OFFMODE_LEN     = OFFMODE_CYC,
   parameter int unsigned FPIN_HIGH_LEN   = FPIN_HIGH_CYC,
   parameter int unsigned FPIN_LOW_LEN    = FPIN_LOW_CYC,
   parameter bit          AUTOREC_BUILD   = 1'b1,
   parameter bit          FPIN_AUTOREC    = 1'b0
)(
   // Clock and reset
   input  wire logic             sys_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             clk_en_in,
   // Comparators and pulse events
   input  wire fpl_pkg::fpl_cmp_t cmp_in,
   input  wire logic             pwm_request_in,
   input  wire logic             pulse_end_in,
   // Gate and controls
   output logic                  gate_drive_out,
   output fpl_pkg::fpl_ctl_t     ctl_out,
   output fpl_pkg::fpl_state_t   state_out,
   output fpl_pkg::fpl_cause_t   cause_out
);
   import fpl_pkg::*;

   fpl_state_t       state;
   fpl_state_t       next_state;
   fpl_cause_t       cause;
   fpl_cause_t       next_cause;
   logic [CNT_W-1:0] fault_cnt;
   logic [CNT_W-1:0] next_fault_cnt;
   logic [CNT_W-1:0] tmr;
   logic [CNT_W-1:0] next_tmr;
   logic [2:0]       short_cnt;
   logic [2:0]       next_short_cnt;
   logic             fault_run;
   logic             next_fault_run;
   // Set when max on-time or max duty started the timer
   logic             max_on_run;
   logic             next_max_on_run;
   logic             gate;
   logic             next_gate;
   logic             low_supply_q;
   logic             ovp_q;
   logic             tsd_q;
   logic             fpin_high_q;
   logic             fpin_low_q;
   logic             release_all;
   logic             switching;
   logic             fault_expired;
   logic             short_trip;
   logic             any_trip;
   logic             autorec_ok;
   logic             restart_ok;

   function automatic logic reached(input logic [CNT_W-1:0] c,
                                    input int unsigned len);
      reached = (c >= CNT_W'(len - 1));
   endfunction

   // =====================================================
   // Qualification filters
   assign switching = (state == FPL_SOFTSTART) || (state == FPL_RUN);

   fpl_qual #(.LEN(SUPPLY_QUAL_CYC)) u_low_supply (
      .sys_clk_in    (sys_clk_in),
      .reset_n_in    (reset_n_in),
      .clk_en_in     (clk_en_in),
      .level_in      (cmp_in.supply_below_off),
      .clear_in      (!switching),
      .qualified_out (low_supply_q)
   ); // [R7]

   fpl_qual #(.LEN(SUPPLY_QUAL_CYC)) u_ovp (
      .sys_clk_in    (sys_clk_in),
      .reset_n_in    (reset_n_in),
      .clk_en_in     (clk_en_in),
      .level_in      (cmp_in.supply_overvoltage),
      .clear_in      (!switching),
      .qualified_out (ovp_q)
   );

   fpl_qual #(.LEN(TSD_QUAL_CYC)) u_tsd (
      .sys_clk_in    (sys_clk_in),
      .reset_n_in    (reset_n_in),
      .clk_en_in     (clk_en_in),
      .level_in      (cmp_in.thermal_shutdown_flag),
      .clear_in      (1'b0),
      .qualified_out (tsd_q)
   ); // [R15]

   // High threshold watched from turn-on, low only after soft-start
   fpl_qual #(.LEN(FPIN_HIGH_LEN)) u_fpin_high (
      .sys_clk_in    (sys_clk_in),
      .reset_n_in    (reset_n_in),
      .clk_en_in     (clk_en_in),
      .level_in      (cmp_in.fpin_high),
      .clear_in      (!(switching || state == FPL_IDLE)
                      || !cmp_in.supply_above_on && state == FPL_IDLE),
      .qualified_out (fpin_high_q)
   ); // [R10] [R12]

   fpl_qual #(.LEN(FPIN_LOW_LEN)) u_fpin_low (
      .sys_clk_in    (sys_clk_in),
      .reset_n_in    (reset_n_in),
      .clk_en_in     (clk_en_in),
      .level_in      (cmp_in.fpin_low),
      .clear_in      (state != FPL_RUN),
      .qualified_out (fpin_low_q)
   ); // [R10] [R13]

   // =====================================================
   // Trip decode
   assign release_all   = cmp_in.brown_out || cmp_in.supply_reset; // [R5] [R11]
   assign fault_expired = fault_run && reached(fault_cnt, FAULT_TIMER_LEN);
   assign short_trip    = pulse_end_in && cmp_in.short_sense
                          && (short_cnt == 3'(SHORT_PULSES - 1)); // [R6]
   assign any_trip      = switching && (fault_expired || short_trip
                          || low_supply_q || ovp_q || fpin_high_q
                          || fpin_low_q); // [R8]
   // Causes that autorecovery may not clear
   assign autorec_ok    = AUTOREC_BUILD && !cause.max_on && !cause.overvoltage
                          && !(cause.fault_pin && !FPIN_AUTOREC); // [R9] [R17]
   assign restart_ok    = cmp_in.line_start_ok && cmp_in.supply_above_on;

   // =====================================================
   // Fault timer and short-pulse count
   always_comb begin
      next_fault_run  = fault_run;
      next_fault_cnt  = fault_cnt;
      next_max_on_run = max_on_run;
      next_short_cnt  = short_cnt;
      if (fault_run && !fault_expired) begin
         next_fault_cnt = fault_cnt + CNT_W'(1); // [R1]
      end
      if (!switching) begin
         next_fault_run  = 1'b0;
         next_fault_cnt  = '0;
         next_max_on_run = 1'b0;
         next_short_cnt  = SHORT_CNT_RESET;
      end else begin
         if (pulse_end_in && (cmp_in.max_on_end || cmp_in.max_duty_end)) begin
            next_fault_run  = 1'b1; // [R3]
            next_max_on_run = 1'b1;
         end else if (cmp_in.ilim_reached) begin
            next_fault_run = 1'b1; // [R1]
         end else if (fault_run && !max_on_run && !fault_expired) begin
            next_fault_run = 1'b0; // [R2]
            next_fault_cnt = '0;
         end
         if (pulse_end_in) begin
            next_short_cnt = cmp_in.short_sense ? short_cnt + 3'h1
                                                : SHORT_CNT_RESET; // [R6]
         end
      end
   end

   // =====================================================
   // Fault timer and short-pulse count registers
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         fault_run  <= 1'b0;
         fault_cnt  <= '0;
         max_on_run <= 1'b0;
         short_cnt  <= SHORT_CNT_RESET;
      end else if (clk_en_in) begin
         fault_run  <= next_fault_run;
         fault_cnt  <= next_fault_cnt;
         max_on_run <= next_max_on_run;
         short_cnt  <= next_short_cnt;
      end
   end

   // =====================================================
   // Main state machine
   always_comb begin
      next_state = state;
      next_cause = cause;
      next_tmr   = tmr + CNT_W'(1);
      next_gate  = 1'b0;
      if (tsd_q && state != FPL_THERMAL) begin
         next_state = FPL_THERMAL; // [R15]
         next_tmr   = '0;
      end else if (cmp_in.brown_out && state != FPL_STOPPED) begin
         next_state = FPL_STOPPED; // [R18]
         next_cause = '0;
      end else begin
         case (state)
            FPL_IDLE: begin
               next_tmr = '0;
               if (cmp_in.supply_reset) begin
                  next_cause = '0;
               end else if (restart_ok && !cmp_in.fpin_high) begin
                  next_state = FPL_SOFTSTART; // [R12]
               end
            end
            FPL_SOFTSTART, FPL_RUN: begin
               next_gate = pwm_request_in;
               if (state == FPL_SOFTSTART && reached(tmr, SOFTSTART_LEN)) begin
                  next_state = FPL_RUN; // [R13]
                  next_tmr   = '0;
               end
               if (state == FPL_RUN) begin
                  next_tmr = cmp_in.feedback_below_off ? tmr + CNT_W'(1) : '0;
                  if (reached(tmr, OFFMODE_LEN)) begin
                     next_state = FPL_OFFMODE; // [R19]
                     next_gate  = 1'b0;
                  end
               end
               if (any_trip) begin
                  next_state = FPL_LATCHED; // [R1]
                  next_gate  = 1'b0;
                  next_tmr   = '0;
                  next_cause.overcurrent   = fault_expired && cmp_in.ilim_reached;
                  next_cause.max_on        = fault_expired && !cmp_in.ilim_reached;
                  next_cause.winding_short = short_trip;
                  next_cause.low_supply    = low_supply_q;
                  next_cause.overvoltage   = ovp_q;
                  next_cause.fault_pin     = fpin_high_q || fpin_low_q;
               end
            end
            FPL_LATCHED: begin
               if (cmp_in.supply_reset) begin
                  next_state = FPL_IDLE; // [R5] [R11]
                  next_cause = '0;
               end else if (autorec_ok && reached(tmr, AUTOREC_LEN)) begin
                  next_state = FPL_IDLE; // [R4]
                  next_cause = '0;
               end
            end
            FPL_STOPPED: begin
               if (!release_all || cmp_in.supply_reset) begin
                  if (restart_ok) begin
                     next_state = FPL_IDLE; // [R18]
                  end
               end
            end
            FPL_THERMAL: begin
               if (!tsd_q && restart_ok) begin
                  next_state = FPL_IDLE; // [R16]
               end
            end
            FPL_OFFMODE: begin
               if (restart_ok && cmp_in.feedback_above_on) begin
                  next_state = FPL_IDLE; // [R19]
               end
            end
            default: next_state = FPL_IDLE;
         endcase
      end
   end

   // =====================================================
   // State registers
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         state <= FPL_IDLE; // [R5]
         cause <= '0;
         tmr   <= '0;
         gate  <= 1'b0;
      end else if (clk_en_in) begin
         state <= next_state;
         cause <= next_cause;
         tmr   <= next_tmr;
         gate  <= next_gate;
      end
   end

   // =====================================================
   // Outputs
   assign gate_drive_out = gate && !tsd_q; // [R15]
   assign state_out      = state;
   assign cause_out      = cause;
   assign ctl_out.gate_enable          = switching;
   assign ctl_out.softstart_active     = (state == FPL_SOFTSTART);
   assign ctl_out.doubled_bias_current = (state == FPL_SOFTSTART); // [R14]
   assign ctl_out.startup_source_en    = (state != FPL_THERMAL);
   assign ctl_out.internal_supply_en   = (state != FPL_OFFMODE); // [R15]
endmodule

/* fpl_pkg.sv */
package fpl_pkg;
   // =====================================================
   // Clock and timing
   localparam int unsigned CLK_MHZ            = 125;
   localparam int unsigned SUPPLY_QUAL_US     = 10;
   localparam int unsigned TSD_QUAL_US        = 10;
   localparam int unsigned FPIN_HIGH_BLANK_US = 50;
   localparam int unsigned FPIN_LOW_BLANK_US  = 350;
   localparam int unsigned SUPPLY_QUAL_CYC    = SUPPLY_QUAL_US * CLK_MHZ;
   localparam int unsigned TSD_QUAL_CYC       = TSD_QUAL_US * CLK_MHZ;
   localparam int unsigned FPIN_HIGH_CYC      = FPIN_HIGH_BLANK_US * CLK_MHZ;
   localparam int unsigned FPIN_LOW_CYC       = FPIN_LOW_BLANK_US * CLK_MHZ;
   // Long counts, defaults for top-level parameters; short-pulse and counter settings
   localparam int unsigned FAULT_TIMER_MS     = 128;
   localparam int unsigned AUTOREC_MS         = 1000;
   localparam int unsigned SOFTSTART_MS       = 4;
   localparam int unsigned OFFMODE_MS         = 500;
   localparam int unsigned FAULT_TIMER_CYC    = FAULT_TIMER_MS * 1000 * CLK_MHZ;
   localparam int unsigned AUTOREC_CYC        = AUTOREC_MS * 1000 * CLK_MHZ;
   localparam int unsigned SOFTSTART_CYC      = SOFTSTART_MS * 1000 * CLK_MHZ;
   localparam int unsigned OFFMODE_CYC        = OFFMODE_MS * 1000 * CLK_MHZ;
   localparam int unsigned SHORT_PULSES       = 4;
   localparam int          CNT_W              = 32;
   localparam logic [2:0]  SHORT_CNT_RESET    = 3'h0;

   // =====================================================
   // Operating states
   typedef enum logic [2:0] {
      FPL_IDLE,
      FPL_SOFTSTART,
      FPL_RUN,
      FPL_LATCHED,
      FPL_STOPPED,
      FPL_THERMAL,
      FPL_OFFMODE
   } fpl_state_t;

   // =====================================================
   // Comparator bundle from the analog front end
   typedef struct packed {
      logic ilim_reached;
      logic short_sense;
      logic max_on_end;
      logic max_duty_end;
      logic supply_below_off;
      logic supply_above_on;
      logic supply_reset;
      logic supply_overvoltage;
      logic fpin_high;
      logic fpin_low;
      logic thermal_shutdown_flag;
      logic brown_out;
      logic line_start_ok;
      logic feedback_below_off;
      logic feedback_above_on;
   } fpl_cmp_t;

   // Controls returned to the analog side
   typedef struct packed {
      logic gate_enable;
      logic softstart_active;
      logic doubled_bias_current;
      logic startup_source_en;
      logic internal_supply_en;
   } fpl_ctl_t;

   // Latch causes
   typedef struct packed {
      logic overcurrent;
      logic winding_short;
      logic low_supply;
      logic max_on;
      logic fault_pin;
      logic overvoltage;
   } fpl_cause_t;
endpackage

/* fpl_qual.sv */
`timescale 1ns/1ps
module fpl_qual
   import fpl_pkg::*;
#(
   parameter int unsigned LEN = 1
)(
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic clk_en_in,
   // Level to qualify
   input  wire logic level_in,
   input  wire logic clear_in,
   output logic      qualified_out
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic             next_qualified;

   // =====================================================
   // Counts how long the level has stood
   always_comb begin
      next_count     = count;
      next_qualified = qualified_out;
      if (clear_in || !level_in) begin
         next_count     = '0;
         next_qualified = 1'b0;
      end else if (count >= CNT_W'(LEN - 1)) begin
         next_qualified = 1'b1;
      end else begin
         next_count = count + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         count         <= '0;
         qualified_out <= 1'b0;
      end else if (clk_en_in) begin
         count         <= next_count;
         qualified_out <= next_qualified;
      end
   end
endmodule

/* fpl_gate_model.sv */
`timescale 1ns/1ps
module fpl_gate_model (
   // Clock and gate
   input  wire logic sys_clk_in,
   input  wire logic gate_drive_in,
   // Fault injection
   input  wire logic short_mode_in,
   input  wire logic max_on_mode_in,
   // Sense results
   output logic      pulse_end_out,
   output logic      short_sense_out,
   output logic      max_on_end_out
);
   logic gate_q;
   always_ff @(posedge sys_clk_in) begin
      gate_q <= gate_drive_in;
   end
   // Pulse end in the cycle after the gate falls
   assign pulse_end_out   = gate_q & ~gate_drive_in;
   // Outside a pulse end the sense lines carry no meaning
   assign short_sense_out = pulse_end_out ? short_mode_in : ~short_mode_in;
   assign max_on_end_out  = pulse_end_out ? max_on_mode_in : ~max_on_mode_in;
endmodule

/* fpl_top_props.sv */
`timescale 1ns/1ps
module fpl_top_props
   import fpl_pkg::*;
#(
   parameter int unsigned FAULT_TIMER_LEN = 20,
   parameter int unsigned AUTOREC_LEN     = 30
)(
   // Clock and reset
   input wire logic                sys_clk_in,
   input wire logic                reset_n_in,
   input wire logic                clk_en_in,
   // Watched ports
   input wire fpl_pkg::fpl_cmp_t   cmp_in,
   input wire logic                pwm_request_in,
   input wire logic                pulse_end_in,
   input wire logic                gate_drive_out,
   input wire fpl_pkg::fpl_ctl_t   ctl_out,
   input wire fpl_pkg::fpl_state_t state_out,
   input wire fpl_pkg::fpl_cause_t cause_out
);
   localparam int AR_MAX = AUTOREC_LEN + 4;
   logic [2:0]  sc;
   logic [2:0]  next_sc;
   logic [31:0] ic;
   logic [31:0] next_ic;
   fpl_state_t  prev_st;
   fpl_cmp_t    prev_cmp;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // ==========
   // Run counters
   always_comb begin
      next_sc = sc;
      next_ic = '0;
      if (pulse_end_in) begin
         next_sc = cmp_in.short_sense ? sc + 3'h1 : 3'h0;
      end
      if (state_out == FPL_RUN && cmp_in.ilim_reached) begin
         next_ic = ic + 32'h1;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      prev_st  <= state_out;
      prev_cmp <= cmp_in;
      if (!reset_n_in) begin
         sc <= 3'h0;
         ic <= '0;
      end else if (clk_en_in) begin
         sc <= next_sc;
         ic <= next_ic;
      end
   end
   // ==========
   // Properties
   a_gate_latched: assert property (
      state_out == FPL_LATCHED && prev_st == FPL_LATCHED
      |-> !gate_drive_out) else $error("gate active while latched");
   a_timer_expiry: assert property (
      ic == FAULT_TIMER_LEN |-> ##[0:2] state_out == FPL_LATCHED)
      else $error("fault timer expiry without latch");
   a_short_trip: assert property (
      pulse_end_in && cmp_in.short_sense && sc == 3'h3 && state_out == FPL_RUN
      |-> ##[1:2] state_out == FPL_LATCHED) else $error("no short latch");
   a_autorec_release: assert property (
      state_out == FPL_LATCHED && cause_out.overcurrent && !cmp_in.brown_out
      |-> ##[1:AR_MAX] state_out != FPL_LATCHED) else $error("no restart");
   a_latch_kept: assert property (
      state_out == FPL_LATCHED && !cmp_in.brown_out && !cmp_in.supply_reset
      && (cause_out.max_on || cause_out.fault_pin || cause_out.overvoltage)
      |=> state_out == FPL_LATCHED) else $error("latch released early");
   a_brownout_stop: assert property (
      clk_en_in && cmp_in.brown_out |=> state_out == FPL_STOPPED
      && cause_out == '0) else $error("brown-out did not stop");
   a_bias_soft: assert property (
      ctl_out.doubled_bias_current == (state_out == FPL_SOFTSTART))
      else $error("bias current select wrong");
   a_start_window: assert property (
      state_out == FPL_SOFTSTART && prev_st == FPL_IDLE
      |-> prev_cmp.supply_above_on && prev_cmp.line_start_ok
      && !prev_cmp.fpin_high) else $error("start outside window");
   c_latched: cover property (state_out == FPL_LATCHED);
   c_thermal: cover property (state_out == FPL_THERMAL);
   c_stopped: cover property (state_out == FPL_STOPPED);
endmodule
bind fpl_top fpl_top_props #(
   .FAULT_TIMER_LEN(FAULT_TIMER_LEN),
   .AUTOREC_LEN    (AUTOREC_LEN)
) u_props (
   .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
   .cmp_in(cmp_in), .pwm_request_in(pwm_request_in),
   .pulse_end_in(pulse_end_in), .gate_drive_out(gate_drive_out),
   .ctl_out(ctl_out), .state_out(state_out), .cause_out(cause_out)
);

/* tb_fpl_top.sv */
`timescale 1ns/1ps
module tb_fpl_top;
   import fpl_pkg::*;
   // ==========
   // Setup
   localparam int FT = 20;
   localparam int AR = 30;
   localparam int SS = 20;
   localparam int OM = 20;
   localparam int FH = 10;
   localparam int FL = 10;
   localparam int QL = SUPPLY_QUAL_CYC;
   localparam logic [14:0] BASE = 15'h0204;
   typedef struct {
      logic [14:0] stim;
      int          hold;
      int          gap;
      fpl_state_t  st;
      logic [5:0]  cause;
   } fpl_row_t;
   fpl_row_t rows [11] = '{
      '{15'h4000, FT + 3, 2, FPL_LATCHED, 6'h20},
      '{15'h4000, FT - 3, 4, FPL_RUN, 6'h00},
      '{15'h0400, QL + 3, 2, FPL_LATCHED, 6'h08},
      '{15'h0080, QL + 3, 2, FPL_LATCHED, 6'h01},
      '{15'h0040, FH + 3, 2, FPL_LATCHED, 6'h02},
      '{15'h0040, FH - 3, FH, FPL_RUN, 6'h00},
      '{15'h0020, FL + 3, 2, FPL_LATCHED, 6'h02},
      '{15'h0020, FL - 3, FL, FPL_RUN, 6'h00},
      '{15'h0010, QL + 3, 0, FPL_THERMAL, 6'h00},
      '{15'h0008, 2, 0, FPL_STOPPED, 6'h00},
      '{15'h0002, OM + 3, 0, FPL_OFFMODE, 6'h00}
   };
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       pwm = 1'b0;
   logic       short_mode = 1'b0;
   logic       max_on_mode = 1'b0;
   logic       pe, ss, mo, gate;
   fpl_cmp_t   cmp = '0;
   fpl_cmp_t   cmp_dut;
   fpl_ctl_t   ctl;
   fpl_state_t state;
   fpl_cause_t cause;
   int         n_fail = 0;
   int         samples_checked = 0;
   int         ticks = 0;
   always #4 clk = ~clk;
   always_comb begin
      cmp_dut = cmp;
      cmp_dut.short_sense = ss;
      cmp_dut.max_on_end = mo;
   end
   fpl_top #(.FAULT_TIMER_LEN(FT), .AUTOREC_LEN(AR), .SOFTSTART_LEN(SS),
      .OFFMODE_LEN(OM), .FPIN_HIGH_LEN(FH), .FPIN_LOW_LEN(FL)) dut (
      .sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
      .cmp_in(cmp_dut), .pwm_request_in(pwm), .pulse_end_in(pe),
      .gate_drive_out(gate), .ctl_out(ctl), .state_out(state),
      .cause_out(cause));
   fpl_gate_model peer (.sys_clk_in(clk), .gate_drive_in(gate),
      .short_mode_in(short_mode), .max_on_mode_in(max_on_mode),
      .pulse_end_out(pe), .short_sense_out(ss), .max_on_end_out(mo));
   // ==========
   // Drive pulses and hang guard
   always @(posedge clk) begin
      #1;
      ticks = ticks + 1;
      pwm = ticks[2];
      if (ticks == 20000) begin
         n_fail = n_fail + 1;
         final_report();
      end
   end
   // ==========
   // Tasks
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk iff pe);
         #1;
      end
   endtask
   task automatic burst(input logic [14:0] stim, input int n);
      cmp = BASE | stim;
      cyc(n);
      cmp = BASE;
   endtask
   task automatic wait_st(input fpl_state_t s, input int lim);
      for (int k = 0; k < lim && state !== s; k++) begin
         cyc(1);
      end
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bring_up();
      rst_n = 1'b0;
      cyc(1);
      cmp = '0;
      cyc(7);
      chk({state, gate, cause, ctl}, 15'h0003);
      rst_n = 1'b1;
      cmp = BASE;
      cyc(SS + 4);
      chk(state, FPL_RUN);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========
   // Sequence
   initial begin
      foreach (rows[i]) begin
         bring_up();
         burst(rows[i].stim, rows[i].hold);
         cyc(rows[i].gap);
         chk({state, cause}, {rows[i].st, rows[i].cause});
      end
      chk(ctl, 5'h02);
      cyc(1);
      cmp = BASE | 15'h0001;
      wait_st(FPL_SOFTSTART, 5);
      chk(state, FPL_SOFTSTART);
      bring_up();
      burst(15'h4000, FT - 3);
      cyc(1);
      burst(15'h4000, FT - 3);
      cyc(3);
      chk(state, FPL_RUN);
      burst(15'h4000, FT + 3);
      chk({state, cause}, {FPL_LATCHED, 6'h20});
      cyc(AR + 6);
      chk({state, ctl.doubled_bias_current}, {FPL_SOFTSTART, 1'b1});
      bring_up();
      max_on_mode = 1'b1;
      cyc(FT + 12);
      max_on_mode = 1'b0;
      chk({state, cause}, {FPL_LATCHED, 6'h04});
      cyc(AR + 6);
      chk(state, FPL_LATCHED);
      cmp = 15'h0100;
      cyc(2);
      chk({state, cause}, {FPL_IDLE, 6'h00});
      bring_up();
      short_mode = 1'b1;
      pulses(3);
      short_mode = 1'b0;
      pulses(1);
      short_mode = 1'b1;
      pulses(3);
      chk(state, FPL_RUN);
      pulses(1);
      cyc(2);
      short_mode = 1'b0;
      chk({state, cause}, {FPL_LATCHED, 6'h10});
      rst_n = 1'b0;
      cyc(8);
      rst_n = 1'b1;
      cmp = BASE | 15'h0040;
      cyc(5);
      chk(state, FPL_IDLE);
      cmp = BASE | 15'h0020;
      cyc(14);
      chk({state, ctl.doubled_bias_current}, {FPL_SOFTSTART, 1'b1});
      cyc(SS + 2);
      chk({state, cause}, {FPL_LATCHED, 6'h02});
      cmp = BASE | 15'h0008;
      cyc(2);
      chk({state, cause}, {FPL_STOPPED, 6'h00});
      cmp = 15'h0200;
      cyc(4);
      chk(state, FPL_STOPPED);
      cmp = BASE;
      wait_st(FPL_SOFTSTART, 20);
      chk(state, FPL_SOFTSTART);
      cyc(SS + 2);
      cmp = BASE | 15'h0010;
      cyc(QL + 3);
      chk({state, gate, ctl}, {FPL_THERMAL, 1'b0, 5'h01});
      cmp = BASE;
      wait_st(FPL_SOFTSTART, QL + 10);
      chk(state, FPL_SOFTSTART);
      final_report();
   end
endmodule
